// ===== logic/dsq_flow.sv
// Module: program counter, sector counter, error flags and checksum setup of the disk microsequencer
//
// The implementer's own choice: the APB interface to the registers.
module dsq_flow
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_end,
  input wire dsq_pkg::dsq_instr_type instr_flags,
  input wire logic id_retry,
  input wire logic data_field_start,
  input wire logic kill,
  input wire dsq_pkg::dsq_error_type err_event,
  output logic [4:0] cs_address,
  output logic seq_running,
  output logic crc_hold_zero,
  output logic crc_hold_ones,
  output logic ecc_hold_zero,
  output logic crc_start_ones,
  output logic sync_in_rs_code_bit,
  output logic sync_in_id_check_bit,
  output logic rs_degree_select,
  output logic interleave_way_select
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [4:0] holding;
  logic [4:0] addr_count;
  logic [4:0] loop_addr;
  logic [4:0] skip_addr;
  logic [7:0] checksum_control;
  logic [7:0] rs_param;
  logic [7:0] sector_iteration_count;
  dsq_pkg::dsq_state_type state;
  dsq_pkg::dsq_state_type next_state;
  logic [4:0] next_addr;
  logic [7:0] next_count;
  logic checksum_error_flag;
  logic id_crc_error_flag;
  logic data_ecc_error_flag;
  logic [4:0] interleave_error_flags;
  logic sync_search_error_flag;
  logic compare_error_flag;
  logic buffer_parity_error_flag;
  logic halt_pending;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Byte address is four times the register index
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:2] == {2'b00, idx});
  endfunction : hit

  // Control store wraps from the last word back to zero
  function automatic logic [4:0] step(input logic [4:0] a);
    step = a + 5'h01;
  endfunction : step

  wire access = psel && penable && clk_en;
  wire wr = access && pwrite;
  wire rd_ok = hit(paddr, dsq_pkg::IDX_ORIGIN) || hit(paddr, dsq_pkg::IDX_LOOP)
    || hit(paddr, dsq_pkg::IDX_CKCTL) || hit(paddr, dsq_pkg::IDX_SECCOUNT)
    || hit(paddr, dsq_pkg::IDX_RSPARAM) || hit(paddr, dsq_pkg::IDX_STATUS)
    || hit(paddr, dsq_pkg::IDX_SKIP) || hit(paddr, dsq_pkg::IDX_WINDOW)
    || hit(paddr, dsq_pkg::IDX_ERRSTAT);
  wire wr_origin = wr && hit(paddr, dsq_pkg::IDX_ORIGIN);
  wire wr_loop = wr && hit(paddr, dsq_pkg::IDX_LOOP);
  wire wr_ckctl = wr && hit(paddr, dsq_pkg::IDX_CKCTL);
  wire wr_count = wr && hit(paddr, dsq_pkg::IDX_SECCOUNT);
  wire wr_rs = wr && hit(paddr, dsq_pkg::IDX_RSPARAM);
  wire wr_skip = wr && hit(paddr, dsq_pkg::IDX_SKIP);
  // Window register stands in for the control store; a write only steps the counter and pwdata is not used
  wire wr_window = wr && hit(paddr, dsq_pkg::IDX_WINDOW);
  wire wr_errstat = wr && hit(paddr, dsq_pkg::IDX_ERRSTAT);
  wire [7:0] wbyte = pwdata[7:0];

  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_ok;

  // ----------------------------------------------------------------
  // Error masking and flow decisions
  // ----------------------------------------------------------------
  wire ignore_err = checksum_control[dsq_pkg::CK_IGNORE];
  wire no_parity = checksum_control[dsq_pkg::CK_NOPARITY];
  wire ck_seen = checksum_error_flag && !ignore_err;
  wire par_seen = buffer_parity_error_flag && !no_parity;
  wire retry_now = instr_flags.retry_bit && (ck_seen || compare_error_flag || sync_search_error_flag);
  // Fail halts on checksum, compare, sync-search or parity error, checksum included unless ignored, parity unless disabled
  wire fail_now = instr_flags.fail_bit
    && (ck_seen || compare_error_flag || sync_search_error_flag || par_seen);
  wire running = (state == dsq_pkg::DSQ_RUNNING);
  // More sectors still to do
  wire count_live = (sector_iteration_count != dsq_pkg::COUNT_ZERO);
  wire errors_set = ck_seen || id_crc_error_flag || data_ecc_error_flag
    || sync_search_error_flag || compare_error_flag;

  // ----------------------------------------------------------------
  // Next program counter and state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_addr = addr_count;
    next_state = state;
    if (wr_origin)
    begin
      next_addr = wbyte[4:0];
      if (count_live)
      begin
        next_state = dsq_pkg::DSQ_RUNNING;
      end
    end
    else if (wr_window)
    begin
      next_addr = step(addr_count);
    end
    else if (wr_count && (wbyte != dsq_pkg::COUNT_ZERO) && !running)
    begin
      next_addr = holding;
      next_state = dsq_pkg::DSQ_RUNNING;
    end
    else if (running && id_retry)
    begin
      next_addr = loop_addr;
    end
    else if (running && instr_end)
    begin
      if (fail_now)
      begin
        next_state = dsq_pkg::DSQ_STOPPED;
      end
      else if (retry_now)
      begin
        next_addr = loop_addr;
      end
      else if (instr_flags.skip_enable_bit)
      begin
        next_addr = skip_addr;
      end
      else if (instr_flags.jump_enable_bit && !halt_pending && count_live)
      begin
        next_addr = loop_addr;
      end
      else if (instr_flags.stop_bit || (instr_flags.jump_enable_bit && halt_pending))
      begin
        // Address stays on the halting instruction for readback
        next_state = dsq_pkg::DSQ_DONE;
      end
      else
      begin
        next_addr = step(addr_count);
      end
    end
  end

  // Count: kill wins, then processor write, then data-field decrement
  always_comb
  begin
    next_count = sector_iteration_count;
    if (kill)
    begin
      next_count = dsq_pkg::COUNT_ZERO;
    end
    else if (wr_count)
    begin
      next_count = wbyte;
    end
    else if (running && data_field_start && count_live)
    begin
      next_count = sector_iteration_count - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= dsq_pkg::DSQ_STOPPED;
      addr_count <= dsq_pkg::ADDR_ZERO;
      sector_iteration_count <= dsq_pkg::COUNT_ZERO;
      halt_pending <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= kill ? dsq_pkg::DSQ_STOPPED : next_state;
      addr_count <= next_addr;
      sector_iteration_count <= next_count;
      // Zero written mid-run ends the loop at the current sector
      if (wr_count)
      begin
        halt_pending <= running && (wbyte == dsq_pkg::COUNT_ZERO);
      end
      else if (!running)
      begin
        halt_pending <= 1'b0;
      end
    end
  end

  // Holding, loop and skip are not reset, cleared here only for a known start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      holding <= dsq_pkg::ADDR_ZERO;
      loop_addr <= dsq_pkg::ADDR_ZERO;
      skip_addr <= dsq_pkg::ADDR_ZERO;
      checksum_control <= dsq_pkg::CKCTL_RESET;
      rs_param <= dsq_pkg::RSPARAM_RESET;
    end
    else if (clk_en)
    begin
      if (wr_origin)
      begin
        holding <= wbyte[4:0];
      end
      if (wr_loop)
      begin
        loop_addr <= wbyte[4:0];
      end
      if (wr_skip)
      begin
        skip_addr <= wbyte[4:0];
      end
      if (wr_ckctl)
      begin
        checksum_control <= {2'b00, wbyte[5:1], 1'b0};
      end
      if (wr_rs)
      begin
        rs_param <= {4'h0, wbyte[3:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Error flags: a new event beats a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      checksum_error_flag <= 1'b0;
      id_crc_error_flag <= 1'b0;
      data_ecc_error_flag <= 1'b0;
      interleave_error_flags <= 5'h00;
      sync_search_error_flag <= 1'b0;
      compare_error_flag <= 1'b0;
      buffer_parity_error_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      checksum_error_flag <= err_event.checksum || (checksum_error_flag && !wr_origin);
      id_crc_error_flag <= err_event.id_crc || (id_crc_error_flag && !wr_origin);
      data_ecc_error_flag <= err_event.data_ecc || (data_ecc_error_flag && !wr_origin);
      sync_search_error_flag <= err_event.sync_search || (sync_search_error_flag && !wr_origin);
      compare_error_flag <= err_event.compare || (compare_error_flag && !wr_origin);
      buffer_parity_error_flag <= err_event.parity || (buffer_parity_error_flag && !wr_origin);
      // Software may also drop single interleave flags by writing zero
      interleave_error_flags <= err_event.interleave
        | (interleave_error_flags & {5{!wr_origin}} & (wr_errstat ? wbyte[4:0] : 5'h1f));
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] status_byte = {4'h0, 1'b0, errors_set, state == dsq_pkg::DSQ_DONE, running};
  wire [7:0] err_byte = {ck_seen, par_seen, sync_search_error_flag, compare_error_flag,
    data_ecc_error_flag, id_crc_error_flag, 2'b00};
  wire [7:0] rd_byte =
    hit(paddr, dsq_pkg::IDX_ORIGIN) ? {3'b000, addr_count} :
    hit(paddr, dsq_pkg::IDX_SECCOUNT) ? sector_iteration_count :
    hit(paddr, dsq_pkg::IDX_STATUS) ? status_byte :
    hit(paddr, dsq_pkg::IDX_ERRSTAT) ? {3'b000, interleave_error_flags} :
    hit(paddr, dsq_pkg::IDX_WINDOW) ? err_byte : 8'h00;

  // Latched in setup so the value stands through the access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= dsq_pkg::DATA_ZERO;
    end
    else if (clk_en && psel && !penable && !pwrite)
    begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Outputs to control store and checksum logic
  // ----------------------------------------------------------------
  assign cs_address = addr_count;
  assign seq_running = running;
  assign ecc_hold_zero = checksum_control[dsq_pkg::CK_CLEAR];
  assign crc_hold_zero = checksum_control[dsq_pkg::CK_CLEAR];
  // Clear takes priority over preset when both are held
  assign crc_hold_ones = checksum_control[dsq_pkg::CK_PRESET] && !checksum_control[dsq_pkg::CK_CLEAR];
  assign crc_start_ones = checksum_control[dsq_pkg::CK_INIT];
  assign sync_in_rs_code_bit = rs_param[dsq_pkg::RS_SYNC_ECC];
  assign sync_in_id_check_bit = rs_param[dsq_pkg::RS_SYNC_CRC];
  assign rs_degree_select = rs_param[dsq_pkg::RS_DEGREE];
  assign interleave_way_select = rs_param[dsq_pkg::RS_WAYS];

endmodule : dsq_flow

// ===== logic/dsq_pkg.sv
// Package: register map, field positions, reset values and shared types of the sequencer flow block
package dsq_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_ORIGIN = 8'h0c;
  localparam logic [7:0] IDX_LOOP = 8'h0d;
  localparam logic [7:0] IDX_CKCTL = 8'h0e;
  localparam logic [7:0] IDX_SECCOUNT = 8'h0f;
  localparam logic [7:0] IDX_RSPARAM = 8'h10;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] IDX_SKIP = 8'h21;
  localparam logic [7:0] IDX_WINDOW = 8'h22;
  localparam logic [7:0] IDX_ERRSTAT = 8'h23;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CK_CLEAR = 5;
  localparam int CK_PRESET = 4;
  localparam int CK_INIT = 3;
  localparam int CK_IGNORE = 2;
  localparam int CK_NOPARITY = 1;
  localparam int RS_SYNC_ECC = 3;
  localparam int RS_SYNC_CRC = 2;
  localparam int RS_DEGREE = 1;
  localparam int RS_WAYS = 0;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [7:0] CKCTL_RESET = 8'h00;
  localparam logic [7:0] RSPARAM_RESET = 8'h0c;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [4:0] ADDR_ZERO = 5'h00;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    DSQ_STOPPED,
    DSQ_RUNNING,
    DSQ_DONE
  } dsq_state_type;

  // Control-store instruction flags reported at instruction end
  typedef struct packed
  {
    logic skip_enable_bit;
    logic jump_enable_bit;
    logic retry_bit;
    logic stop_bit;
    logic fail_bit;
  } dsq_instr_type;

  // Error events from the data path, one-cycle pulses
  typedef struct packed
  {
    logic checksum;
    logic id_crc;
    logic data_ecc;
    logic [4:0] interleave;
    logic sync_search;
    logic compare;
    logic parity;
  } dsq_error_type;

endpackage : dsq_pkg

// ===== verification/dsq_cpu.sv
// Partner model: local processor driving the register port
module dsq_cpu
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_err;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // Request held from setup until pready is sampled high
  task xfer(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Counter may move between reads; repeat until two agree or four more reads are done
  task rd_stable(input logic [7:0] i, output logic [31:0] q);
    logic [31:0] p;
    xfer(1'b0, i, 8'h00, p);
    repeat (4)
    begin
      xfer(1'b0, i, 8'h00, q);
      if (q === p) break;
      p = q;
    end
  endtask : rd_stable
endmodule : dsq_cpu

// ===== verification/dsq_flow_checker.sv
// Checker: port-level properties of the sequencer flow block
module dsq_flow_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic instr_end,
  input wire dsq_pkg::dsq_instr_type instr_flags,
  input wire logic id_retry,
  input wire logic data_field_start,
  input wire logic kill,
  input wire logic [4:0] cs_address,
  input wire logic seq_running,
  input wire logic crc_hold_zero,
  input wire logic crc_hold_ones,
  input wire logic ecc_hold_zero,
  input wire logic crc_start_ones,
  input wire logic sync_in_rs_code_bit,
  input wire logic sync_in_id_check_bit,
  input wire logic rs_degree_select,
  input wire logic interleave_way_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_ok = psel && penable && pwrite && clk_en && paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0;
  wire logic calm = !instr_end && !id_retry && !kill && !data_field_start;
  wire logic at_org = wr_ok && paddr[9:2] == dsq_pkg::IDX_ORIGIN;
  wire logic at_win = wr_ok && paddr[9:2] == dsq_pkg::IDX_WINDOW && calm;
  wire logic at_ck = wr_ok && paddr[9:2] == dsq_pkg::IDX_CKCTL;
  wire logic at_rs = wr_ok && paddr[9:2] == dsq_pkg::IDX_RSPARAM;
  wire logic at_cnt = wr_ok && paddr[9:2] == dsq_pkg::IDX_SECCOUNT && pwdata[7:0] != 8'h00;
  wire logic plain = clk_en && seq_running && !wr_ok;
  // Shadows of write-only targets, so jumps can be checked against them
  logic [4:0] skip_sh, loop_sh, org_sh;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      skip_sh <= 5'h00;
      loop_sh <= 5'h00;
      org_sh <= 5'h00;
    end
    else
    begin
      if (wr_ok && paddr[9:2] == dsq_pkg::IDX_SKIP) skip_sh <= pwdata[4:0];
      if (wr_ok && paddr[9:2] == dsq_pkg::IDX_LOOP) loop_sh <= pwdata[4:0];
      if (at_org) org_sh <= pwdata[4:0];
    end
  end
  property p_org; at_org |=> cs_address == $past(pwdata[4:0]); endproperty
  a_org: assert property (p_org) else $error("origin write did not load counter");
  property p_win; at_win |=> cs_address == $past(cs_address) + 5'h01; endproperty
  a_win: assert property (p_win) else $error("window write did not step counter");
  property p_go; at_cnt && !seq_running |=> seq_running && cs_address == org_sh; endproperty
  a_go: assert property (p_go) else $error("count write did not start at origin");
  property p_kill; kill && clk_en |=> !seq_running [*2]; endproperty
  a_kill: assert property (p_kill) else $error("kill did not stop sequencer");
  property p_clr; at_ck |=> {crc_hold_zero, ecc_hold_zero} == {2{$past(pwdata[5])}}; endproperty
  a_clr: assert property (p_clr) else $error("clear hold wrong");
  property p_pre; at_ck |=> crc_hold_ones == ($past(pwdata[4]) && !$past(pwdata[5])); endproperty
  a_pre: assert property (p_pre) else $error("preset hold wrong");
  property p_ini; at_ck |=> crc_start_ones == $past(pwdata[3]); endproperty
  a_ini: assert property (p_ini) else $error("initial state select wrong");
  property p_rs;
    at_rs |=> {sync_in_rs_code_bit, sync_in_id_check_bit, rs_degree_select, interleave_way_select} == $past(pwdata[3:0]);
  endproperty
  a_rs: assert property (p_rs) else $error("code parameter bits wrong");
  property p_skip;
    instr_end && plain && instr_flags.skip_enable_bit && !instr_flags.retry_bit && !instr_flags.fail_bit
      |=> cs_address == skip_sh;
  endproperty
  a_skip: assert property (p_skip) else $error("skip did not load skip address");
  property p_idr; id_retry && !instr_end && plain |=> cs_address == loop_sh; endproperty
  a_idr: assert property (p_idr) else $error("id retry did not load loop address");
  c_org: cover property (at_org);
  c_skip: cover property (instr_end && instr_flags.skip_enable_bit);
  c_kill: cover property (kill ##1 !seq_running);
endmodule : dsq_flow_checker

bind dsq_flow dsq_flow_checker dsq_flow_checker_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
  .pwdata, .instr_end, .instr_flags, .id_retry, .data_field_start, .kill, .cs_address, .seq_running,
  .crc_hold_zero, .crc_hold_ones, .ecc_hold_zero, .crc_start_ones, .sync_in_rs_code_bit, .sync_in_id_check_bit,
  .rs_degree_select, .interleave_way_select);

// ===== verification/dsq_flow_tb.sv
// Testbench: register, program-flow and checksum-setup scenarios of the sequencer block
module dsq_flow_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic instr_end = 1'b0;
  logic id_retry = 1'b0;
  logic data_field_start = 1'b0;
  logic kill = 1'b0;
  dsq_pkg::dsq_instr_type instr_flags = '0;
  dsq_pkg::dsq_error_type err_event = '0;
  logic psel, penable, pwrite, pready, pslverr, seq_running;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [4:0] cs_address;
  logic crc_hold_zero, crc_hold_ones, ecc_hold_zero, crc_start_ones;
  logic sync_in_rs_code_bit, sync_in_id_check_bit, rs_degree_select, interleave_way_select;
  int n_fail = 0;
  int compares = 0;
  always #12.5 pclk = ~pclk;
  dsq_flow dsq_flow_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .instr_end, .instr_flags, .id_retry, .data_field_start, .kill, .err_event, .cs_address,
    .seq_running, .crc_hold_zero, .crc_hold_ones, .ecc_hold_zero, .crc_start_ones, .sync_in_rs_code_bit,
    .sync_in_id_check_bit, .rs_degree_select, .interleave_way_select);
  dsq_cpu dsq_cpu_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] i, input logic [7:0] d);
    dsq_cpu_i.xfer(1'b1, i, d, rd_data);
    @(negedge pclk);
  endtask : wr
  task rdc(input logic [7:0] i, input logic [31:0] e);
    dsq_cpu_i.xfer(1'b0, i, 8'h00, rd_data);
    chk(rd_data, e);
  endtask : rdc
  // One-cycle event pulse; w = {kill, id_retry, data_field_start, instr_end}
  task ev(input logic [3:0] w, input logic [4:0] f, input logic [10:0] e);
    @(posedge pclk);
    {kill, id_retry, data_field_start, instr_end} <= w;
    instr_flags <= f;
    err_event <= e;
    @(posedge pclk);
    {kill, id_retry, data_field_start, instr_end} <= 4'h0;
    instr_flags <= '0;
    err_event <= '0;
    @(negedge pclk);
  endtask : ev
  task t_reset;
    rdc(dsq_pkg::IDX_SECCOUNT, 8'h00);
    chk({sync_in_rs_code_bit, sync_in_id_check_bit, rs_degree_select, interleave_way_select}, 4'hc);
    rdc(8'h11, 8'h00);
    chk(dsq_cpu_i.last_err, 1'b1);
    chk(pready, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  task t_origin;
    wr(dsq_pkg::IDX_ORIGIN, 8'h13);
    rdc(dsq_pkg::IDX_ORIGIN, 8'h13);
    repeat (3) wr(dsq_pkg::IDX_WINDOW, 8'h00);
    chk(cs_address, 5'h16);
    $display("t_origin done");
  endtask : t_origin
  task t_ckctl;
    wr(dsq_pkg::IDX_CKCTL, 8'h20);
    chk({crc_hold_zero, ecc_hold_zero, crc_hold_ones}, 3'h6);
    wr(dsq_pkg::IDX_CKCTL, 8'h18);
    chk({crc_hold_zero, crc_hold_ones, crc_start_ones}, 3'h3);
    wr(dsq_pkg::IDX_CKCTL, 8'h00);
    chk({crc_hold_zero, ecc_hold_zero, crc_hold_ones, crc_start_ones}, 4'h0);
    wr(dsq_pkg::IDX_RSPARAM, 8'h03);
    chk({sync_in_rs_code_bit, sync_in_id_check_bit, rs_degree_select, interleave_way_select}, 4'h3);
    $display("t_ckctl done");
  endtask : t_ckctl
  task t_run;
    wr(dsq_pkg::IDX_LOOP, 8'h04);
    wr(dsq_pkg::IDX_SKIP, 8'h09);
    wr(dsq_pkg::IDX_ORIGIN, 8'h02);
    wr(dsq_pkg::IDX_SECCOUNT, 8'h02);
    chk({seq_running, cs_address}, 6'h22);
    ev(4'h2, 5'h00, 11'h000);
    rdc(dsq_pkg::IDX_SECCOUNT, 8'h01);
    ev(4'h1, 5'h10, 11'h000);
    chk(cs_address, 5'h09);
    ev(4'h1, 5'h08, 11'h000);
    chk(cs_address, 5'h04);
    ev(4'h1, 5'h00, 11'h000);
    ev(4'h4, 5'h00, 11'h000);
    chk(cs_address, 5'h04);
    ev(4'h2, 5'h00, 11'h000);
    ev(4'h1, 5'h08, 11'h000);
    chk(cs_address, 5'h05);
    ev(4'h1, 5'h02, 11'h000);
    dsq_cpu_i.rd_stable(dsq_pkg::IDX_ORIGIN, rd_data);
    chk({seq_running, rd_data[4:0]}, 6'h05);
    rdc(dsq_pkg::IDX_STATUS, 8'h02);
    wr(dsq_pkg::IDX_SECCOUNT, 8'h03);
    chk({seq_running, cs_address}, 6'h22);
    wr(dsq_pkg::IDX_SECCOUNT, 8'h00);
    ev(4'h1, 5'h08, 11'h000);
    chk(seq_running, 1'b0);
    wr(dsq_pkg::IDX_SECCOUNT, 8'h01);
    ev(4'h8, 5'h00, 11'h000);
    rdc(dsq_pkg::IDX_SECCOUNT, 8'h00);
    chk(seq_running, 1'b0);
    $display("t_run done");
  endtask : t_run
  task t_err;
    wr(dsq_pkg::IDX_ORIGIN, 8'h01);
    wr(dsq_pkg::IDX_LOOP, 8'h07);
    wr(dsq_pkg::IDX_SECCOUNT, 8'h05);
    ev(4'h0, 5'h00, 11'h408);
    ev(4'h1, 5'h04, 11'h000);
    chk(cs_address, 5'h07);
    ev(4'h1, 5'h01, 11'h000);
    chk({seq_running, cs_address}, 6'h07);
    rdc(dsq_pkg::IDX_SECCOUNT, 8'h05);
    rdc(dsq_pkg::IDX_WINDOW, 8'h80);
    rdc(dsq_pkg::IDX_STATUS, 8'h04);
    rdc(dsq_pkg::IDX_ERRSTAT, 8'h01);
    wr(dsq_pkg::IDX_ORIGIN, 8'h03);
    chk({seq_running, cs_address}, 6'h23);
    rdc(dsq_pkg::IDX_WINDOW, 8'h00);
    rdc(dsq_pkg::IDX_ERRSTAT, 8'h00);
    wr(dsq_pkg::IDX_CKCTL, 8'h06);
    ev(4'h0, 5'h00, 11'h709);
    rdc(dsq_pkg::IDX_WINDOW, 8'h0c);
    rdc(dsq_pkg::IDX_ERRSTAT, 8'h01);
    wr(dsq_pkg::IDX_ERRSTAT, 8'h00);
    rdc(dsq_pkg::IDX_ERRSTAT, 8'h00);
    ev(4'h1, 5'h01, 11'h000);
    chk(seq_running, 1'b1);
    ev(4'h8, 5'h00, 11'h000);
    $display("t_err done");
  endtask : t_err
  // Frozen block must ignore port writes
  task t_freeze;
    @(posedge pclk);
    clk_en <= 1'b0;
    wr(dsq_pkg::IDX_ORIGIN, 8'h1f);
    wr(dsq_pkg::IDX_WINDOW, 8'h00);
    chk(cs_address, 5'h04);
    @(posedge pclk);
    clk_en <= 1'b1;
    rdc(dsq_pkg::IDX_ORIGIN, 8'h04);
    wr(dsq_pkg::IDX_SECCOUNT, 8'h01);
    chk({seq_running, cs_address}, 6'h23);
    $display("t_freeze done");
  endtask : t_freeze
  task summarize;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_origin;
    t_ckctl;
    t_run;
    t_err;
    t_freeze;
    summarize;
  end
  initial
  begin
    repeat (4000) @(posedge pclk);
    n_fail++;
    summarize;
  end
endmodule : dsq_flow_tb
